// [src/gate_driver_mode_sequencer.sv]
// Mode sequencer of a three-phase gate driver: modes, supply gating,
// overcurrent filtering and retry. Supply levels, enable, faults and
// phase commands arrive from pins; filter and retry selects and status
// clear come from the serial block on the same clock.
// Operation
// - Four modes in one state machine
// - Low supply: shutdown, only primary regulator
// - Sleep: gates off, phase commands ignored
// - Sleep: chain off, primary and aux on
// - Operating: chain on, primary off, gates follow
// - Fault mode drives fault pin and status
// - Supply up: shutdown to sleep after delay
// - Enable high: sleep to operating after delay
// - Enable low: operating to sleep after delay
// - Supply drop: shutdown, delayed from sleep/fault
// - Fault while operating enters fault mode
// - Cleared recoverable fault returns after delay
// - Further faults stay; disables are ANDed
// - Enable low in fault: sleep after delay
// - Filter 3.2us strap, else four selectable
// - Retry 4000us strap, else 4000/70us
module gate_driver_mode_sequencer #(
   parameter int RETRY_LONG_CYC = mode_seq_pkg::RTY_LONG_CYC // Long retry
) (
   input wire logic clk_sys_i, // 50 MHz clock
   input wire logic rst_i, // Async reset, high
   input wire logic vcc_above_rise_i, // Supply above rising level
   input wire logic vcc_below_fall_i, // Supply below falling level
   input wire logic enable_i, // Enable pin
   input wire logic shunt_trip_i, // Shunt comparator
   input wire logic [2:0] fault_src_i, // Other fault sources
   input wire logic [2:0] high_side_cmd_i, // High side commands
   input wire logic [2:0] low_side_cmd_i, // Low side commands
   input wire logic serial_cfg_i, // Serial config selected
   input wire logic [1:0] overcurrent_filter_sel_i, // Filter select
   input wire logic shunt_trip_retry_sel_i, // Retry select
   input wire logic [3:0] status_clr_i, // Status clear pulse
   output logic primary_regulator_en_o, // Primary regulator on
   output logic aux_regulator_en_o, // Aux regulator on
   output logic buck_boost_en_o, // Buck-boost on
   output logic charge_pump_en_o, // Charge pump on
   output logic drive_regulator_en_o, // Drive regulator on
   output logic [2:0] high_side_gate_o, // High side gates
   output logic [2:0] low_side_gate_o, // Low side gates
   output logic fault_out_n_o, // Fault pin, low active
   output logic [3:0] fault_status_o, // Sticky fault status
   output logic [1:0] mode_o // Current mode code
);

   // Whole state of the block
   typedef struct packed {
      mode_seq_pkg::pins_t s1; // First sync stage
      mode_seq_pkg::pins_t s2; // Second sync stage
      mode_seq_pkg::mode_t mode; // Mode register
      logic [2:0] cond; // Condition being timed
      mode_seq_pkg::dly_cnt_t dly; // Delay counter
      mode_seq_pkg::ocf_cnt_t ocf; // Filter counter
      mode_seq_pkg::rty_cnt_t rty; // Retry counter
      logic trip; // Shunt trip latched
      logic [3:0] seen; // Sources seen in fault
      mode_seq_pkg::outs_t o; // Output flops
   } state_t;

   state_t st_q; // Current state
   state_t st_d; // Next state
   logic [3:0] act_w; // Active fault sources

   // Filter length from select; strap fixes the 3.2us setting (select 2)
   function automatic mode_seq_pkg::ocf_cnt_t ocf_lim(
      input logic ser,
      input logic [1:0] sel
   );
      mode_seq_pkg::ocf_cnt_t r;
      r = mode_seq_pkg::ocf_cnt_t'(mode_seq_pkg::OCF_3P2_CYC);
      if (ser)
      begin
         case (sel)
            2'h0: r = mode_seq_pkg::ocf_cnt_t'(mode_seq_pkg::OCF_1P4_CYC);
            2'h1: r = mode_seq_pkg::ocf_cnt_t'(mode_seq_pkg::OCF_2P2_CYC);
            2'h2: r = mode_seq_pkg::ocf_cnt_t'(mode_seq_pkg::OCF_3P2_CYC);
            default: r = mode_seq_pkg::ocf_cnt_t'(mode_seq_pkg::OCF_5P4_CYC);
         endcase
      end
      return r;
   endfunction

   // Retry length from select; strap gives the long one
   function automatic mode_seq_pkg::rty_cnt_t rty_lim(
      input logic ser,
      input logic sel
   );
      mode_seq_pkg::rty_cnt_t r;
      r = mode_seq_pkg::rty_cnt_t'(RETRY_LONG_CYC);
      if (ser && sel)
      begin
         r = mode_seq_pkg::rty_cnt_t'(mode_seq_pkg::RTY_SHORT_CYC);
      end
      return r;
   endfunction

   // AND of active-low disables over all active sources
   function automatic logic [2:0] dis_and(input logic [3:0] a);
      logic [2:0] r;
      r = 3'h7;
      for (int k = 0; k < 4; k++)
      begin
         if (a[k])
         begin
            r = r & mode_seq_pkg::FAULT_DIS_N[k];
         end
      end
      return r;
   endfunction

   // Shunt trip is source 0, pins give the rest
   assign act_w = {st_q.s2.fsrc, st_q.trip};

   // Next-state logic
   always_comb
   begin
      mode_seq_pkg::pins_t p;
      mode_seq_pkg::pins_t i;
      mode_seq_pkg::dly_cnt_t lim;
      mode_seq_pkg::mode_t tgt;
      mode_seq_pkg::ocf_cnt_t ol;
      mode_seq_pkg::rty_cnt_t rl;
      logic [2:0] c;
      logic [2:0] dis;
      p = '0;
      i = st_q.s2;
      lim = '0;
      tgt = st_q.mode;
      c = mode_seq_pkg::COND_NONE;
      dis = 3'h7;
      ol = ocf_lim(serial_cfg_i, overcurrent_filter_sel_i);
      rl = rty_lim(serial_cfg_i, shunt_trip_retry_sel_i);
      st_d = st_q;
      // Pins into the two-stage synchroniser
      p.vcc_ok = vcc_above_rise_i;
      p.vcc_low = vcc_below_fall_i;
      p.en = enable_i;
      p.shunt_oc = shunt_trip_i;
      p.fsrc = fault_src_i;
      p.hs = high_side_cmd_i;
      p.ls = low_side_cmd_i;
      st_d.s1 = p;
      st_d.s2 = st_q.s1;

      // Overcurrent filter: any gap restarts it, glitches never trip
      st_d.ocf = '0;
      st_d.rty = '0;
      if (st_q.trip)
      begin
         // Retry timer runs while tripped
         if (st_q.rty == rl - 1'h1)
         begin
            st_d.trip = 1'h0;
         end
         else
         begin
            st_d.rty = st_q.rty + 1'h1;
         end
      end
      else if (i.shunt_oc)
      begin
         if (st_q.ocf == ol - 1'h1)
         begin
            st_d.trip = 1'h1;
         end
         else
         begin
            st_d.ocf = st_q.ocf + 1'h1;
         end
      end

      // Sources seen since fault mode was entered
      if (st_q.mode == mode_seq_pkg::MODE_FAULT)
      begin
         st_d.seen = st_q.seen | act_w;
      end
      else
      begin
         st_d.seen = act_w;
      end

      // Mode machine; timed moves name a condition and limit
      case (st_q.mode)
         mode_seq_pkg::MODE_SHDN:
         begin
            if (i.vcc_ok)
            begin
               c = mode_seq_pkg::COND_START;
               lim = mode_seq_pkg::dly_cnt_t'(mode_seq_pkg::START_CYC);
               tgt = mode_seq_pkg::MODE_SLEEP;
            end
         end
         mode_seq_pkg::MODE_SLEEP:
         begin
            // Falling supply is timed here, as in fault mode
            if (i.vcc_low)
            begin
               c = mode_seq_pkg::COND_SHDN;
               lim = mode_seq_pkg::dly_cnt_t'(mode_seq_pkg::SHDN_CYC);
               tgt = mode_seq_pkg::MODE_SHDN;
            end
            else if (i.en)
            begin
               c = mode_seq_pkg::COND_WAKE;
               lim = mode_seq_pkg::dly_cnt_t'(mode_seq_pkg::WAKE_CYC);
               tgt = mode_seq_pkg::MODE_OPER;
            end
         end
         mode_seq_pkg::MODE_OPER:
         begin
            if (i.vcc_low)
            begin
               st_d.mode = mode_seq_pkg::MODE_SHDN;
            end
            else if (|act_w)
            begin
               st_d.mode = mode_seq_pkg::MODE_FAULT;
            end
            else if (!i.en)
            begin
               c = mode_seq_pkg::COND_SLEEP;
               lim = mode_seq_pkg::dly_cnt_t'(mode_seq_pkg::SLEEP_CYC);
               tgt = mode_seq_pkg::MODE_SLEEP;
            end
         end
         mode_seq_pkg::MODE_FAULT:
         begin
            // New faults simply keep us here
            if (i.vcc_low)
            begin
               c = mode_seq_pkg::COND_SHDN;
               lim = mode_seq_pkg::dly_cnt_t'(mode_seq_pkg::SHDN_CYC);
               tgt = mode_seq_pkg::MODE_SHDN;
            end
            else if (!i.en)
            begin
               c = mode_seq_pkg::COND_RCVR_SLP;
               lim = mode_seq_pkg::dly_cnt_t'(mode_seq_pkg::RCVR_CYC);
               tgt = mode_seq_pkg::MODE_SLEEP;
            end
            else if (act_w == 4'h0 &&
                     (st_d.seen & ~mode_seq_pkg::FAULT_RECOVER) == 4'h0)
            begin
               c = mode_seq_pkg::COND_RCVR_OPR;
               lim = mode_seq_pkg::dly_cnt_t'(mode_seq_pkg::RCVR_CYC);
               tgt = mode_seq_pkg::MODE_OPER;
            end
         end
         default:
         begin
            st_d.mode = mode_seq_pkg::MODE_SHDN;
         end
      endcase

      // Delay counter restarts when its condition drops or changes
      st_d.cond = c;
      if (c == mode_seq_pkg::COND_NONE || c != st_q.cond)
      begin
         st_d.dly = '0;
      end
      else if (st_q.dly == lim - 1'h1)
      begin
         st_d.mode = tgt;
         st_d.dly = '0;
         st_d.cond = mode_seq_pkg::COND_NONE;
      end
      else
      begin
         st_d.dly = st_q.dly + 1'h1;
      end

      // Sticky status; in operating or fault mode a new event beats a clear in the same cycle
      st_d.o.status = st_q.o.status & ~status_clr_i;
      if (st_q.mode == mode_seq_pkg::MODE_OPER ||
          st_q.mode == mode_seq_pkg::MODE_FAULT)
      begin
         st_d.o.status = st_d.o.status | act_w;
      end

      // Outputs follow the next mode so they sit in flops
      st_d.o.mode = st_d.mode;
      st_d.o.fault_n = st_d.mode != mode_seq_pkg::MODE_FAULT;
      st_d.o.prim = 1'h0;
      st_d.o.aux = 1'h0;
      st_d.o.bb = 1'h0;
      st_d.o.cp = 1'h0;
      st_d.o.drv = 1'h0;
      st_d.o.hs = 3'h0;
      st_d.o.ls = 3'h0;
      case (st_d.mode)
         mode_seq_pkg::MODE_SHDN:
         begin
            st_d.o.prim = 1'h1;
         end
         mode_seq_pkg::MODE_SLEEP:
         begin
            // Phase commands are ignored here
            st_d.o.prim = 1'h1;
            st_d.o.aux = 1'h1;
         end
         mode_seq_pkg::MODE_OPER:
         begin
            // Both commands high means both gates off
            st_d.o.aux = 1'h1;
            st_d.o.bb = 1'h1;
            st_d.o.cp = 1'h1;
            st_d.o.drv = 1'h1;
            st_d.o.hs = i.hs & ~i.ls;
            st_d.o.ls = i.ls & ~i.hs;
         end
         mode_seq_pkg::MODE_FAULT:
         begin
            // Primary keeps the rail up whenever the chain is cut
            dis = dis_and(act_w);
            st_d.o.bb = dis[mode_seq_pkg::FN_CHAIN];
            st_d.o.cp = dis[mode_seq_pkg::FN_CHAIN];
            st_d.o.drv = dis[mode_seq_pkg::FN_CHAIN];
            st_d.o.prim = !dis[mode_seq_pkg::FN_CHAIN];
            st_d.o.aux = dis[mode_seq_pkg::FN_AUX];
            st_d.o.hs = i.hs & ~i.ls & {3{dis[mode_seq_pkg::FN_GATE]}};
            st_d.o.ls = i.ls & ~i.hs & {3{dis[mode_seq_pkg::FN_GATE]}};
         end
         default:
         begin
            st_d.o.prim = 1'h1;
         end
      endcase
   end

   // State register; reset loads constants only
   always_ff @(posedge clk_sys_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         st_q <= '0;
         st_q.o <= mode_seq_pkg::OUT_RST;
      end
      else
      begin
         st_q <= st_d;
      end
   end

   // Ports straight from flops
   assign primary_regulator_en_o = st_q.o.prim;
   assign aux_regulator_en_o = st_q.o.aux;
   assign buck_boost_en_o = st_q.o.bb;
   assign charge_pump_en_o = st_q.o.cp;
   assign drive_regulator_en_o = st_q.o.drv;
   assign high_side_gate_o = st_q.o.hs;
   assign low_side_gate_o = st_q.o.ls;
   assign fault_out_n_o = st_q.o.fault_n;
   assign fault_status_o = st_q.o.status;
   assign mode_o = st_q.o.mode;

   // Checks on the mode machine and the trip logic
   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (rst_i);

   a_shdn_outputs: assert property (
      st_q.mode == mode_seq_pkg::MODE_SHDN |-> primary_regulator_en_o &&
      !aux_regulator_en_o && !buck_boost_en_o && high_side_gate_o == 3'h0)
      else $error("shutdown outputs wrong");

   a_sleep_outputs: assert property (
      st_q.mode == mode_seq_pkg::MODE_SLEEP |-> high_side_gate_o == 3'h0 &&
      low_side_gate_o == 3'h0 && !buck_boost_en_o && !charge_pump_en_o &&
      !drive_regulator_en_o && primary_regulator_en_o && aux_regulator_en_o)
      else $error("sleep outputs wrong");

   a_oper_supplies: assert property (
      st_q.mode == mode_seq_pkg::MODE_OPER |-> buck_boost_en_o &&
      charge_pump_en_o && !primary_regulator_en_o)
      else $error("operating supplies wrong");

   a_fault_pin: assert property (
      fault_out_n_o != (st_q.mode == mode_seq_pkg::MODE_FAULT))
      else $error("fault pin disagrees with mode");

   a_startup_delay: assert property (
      st_q.mode == mode_seq_pkg::MODE_SLEEP &&
      $past(st_q.mode) == mode_seq_pkg::MODE_SHDN |->
      $past(st_q.dly) == mode_seq_pkg::START_CYC - 1)
      else $error("startup delay wrong");

   a_wake_delay: assert property (
      st_q.mode == mode_seq_pkg::MODE_OPER &&
      $past(st_q.mode) == mode_seq_pkg::MODE_SLEEP |->
      $past(st_q.dly) == mode_seq_pkg::WAKE_CYC - 1 && $past(st_q.s2.en))
      else $error("wake delay wrong");

   a_sleep_entry: assert property (
      st_q.mode == mode_seq_pkg::MODE_SLEEP &&
      $past(st_q.mode) == mode_seq_pkg::MODE_OPER |->
      $past(st_q.dly) == mode_seq_pkg::SLEEP_CYC - 1 && !$past(st_q.s2.en))
      else $error("sleep entry delay wrong");

   a_supply_drop: assert property (
      st_q.mode == mode_seq_pkg::MODE_OPER && st_q.s2.vcc_low |=>
      st_q.mode == mode_seq_pkg::MODE_SHDN)
      else $error("no shutdown on supply drop");

   a_shdn_delay: assert property (
      st_q.mode == mode_seq_pkg::MODE_SHDN && $past(st_q.mode) inside
      {mode_seq_pkg::MODE_SLEEP, mode_seq_pkg::MODE_FAULT} |->
      $past(st_q.dly) == mode_seq_pkg::SHDN_CYC - 1 && $past(st_q.s2.vcc_low))
      else $error("shutdown delay wrong");

   a_fault_entry: assert property (
      st_q.mode == mode_seq_pkg::MODE_OPER && !st_q.s2.vcc_low &&
      act_w != 4'h0 |=> st_q.mode == mode_seq_pkg::MODE_FAULT)
      else $error("fault not entered");

   a_fault_recover: assert property (
      st_q.mode == mode_seq_pkg::MODE_OPER &&
      $past(st_q.mode) == mode_seq_pkg::MODE_FAULT |->
      $past(st_q.dly) == mode_seq_pkg::RCVR_CYC - 1 && $past(act_w) == 4'h0)
      else $error("fault recovery wrong");

   a_fault_hold: assert property (
      st_q.mode == mode_seq_pkg::MODE_FAULT && act_w != 4'h0 &&
      st_q.s2.en && !st_q.s2.vcc_low |=>
      st_q.mode == mode_seq_pkg::MODE_FAULT)
      else $error("left fault mode with fault active");

   a_fault_sleep: assert property (
      st_q.mode == mode_seq_pkg::MODE_SLEEP &&
      $past(st_q.mode) == mode_seq_pkg::MODE_FAULT |->
      $past(st_q.dly) == mode_seq_pkg::RCVR_CYC - 1 && !$past(st_q.s2.en))
      else $error("fault to sleep wrong");

   a_trip_filter: assert property (
      $rose(st_q.trip) |-> $past(st_q.s2.shunt_oc) && $past(st_q.ocf) ==
      ocf_lim($past(serial_cfg_i), $past(overcurrent_filter_sel_i)) - 1)
      else $error("trip before filter time");

   a_trip_retry: assert property (
      $fell(st_q.trip) |-> $past(st_q.rty) ==
      rty_lim($past(serial_cfg_i), $past(shunt_trip_retry_sel_i)) - 1)
      else $error("retry time wrong");

   a_delay_restart: assert property (
      st_q.cond != $past(st_q.cond) |-> st_q.dly == '0)
      else $error("delay not restarted");

   c_startup: cover property (
      $past(st_q.mode) == mode_seq_pkg::MODE_SHDN &&
      st_q.mode == mode_seq_pkg::MODE_SLEEP);
   c_wake: cover property (
      $past(st_q.mode) == mode_seq_pkg::MODE_SLEEP &&
      st_q.mode == mode_seq_pkg::MODE_OPER);
   c_recover: cover property (
      $past(st_q.mode) == mode_seq_pkg::MODE_FAULT &&
      st_q.mode == mode_seq_pkg::MODE_OPER);
   c_retry: cover property ($fell(st_q.trip));

endmodule

// [src/mode_seq_pkg.sv]
// Constants, types and fault matrix for the gate driver mode sequencer.
// Assumes a 50 MHz system clock and an asynchronous power-on reset.
package mode_seq_pkg;

   // System clock period, ns
   localparam int CLK_NS = 20;

   // Overcurrent filter times, ns
   localparam int OCF_1P4_NS = 1400;
   localparam int OCF_2P2_NS = 2200;
   localparam int OCF_3P2_NS = 3200;
   localparam int OCF_5P4_NS = 5400;
   localparam int OCF_1P4_CYC = OCF_1P4_NS / CLK_NS;
   localparam int OCF_2P2_CYC = OCF_2P2_NS / CLK_NS;
   localparam int OCF_3P2_CYC = OCF_3P2_NS / CLK_NS;
   localparam int OCF_5P4_CYC = OCF_5P4_NS / CLK_NS;

   // Shunt trip retry times, us
   localparam int RTY_LONG_US = 4000;
   localparam int RTY_SHORT_US = 70;
   localparam int RTY_LONG_CYC = RTY_LONG_US * 1000 / CLK_NS;
   localparam int RTY_SHORT_CYC = RTY_SHORT_US * 1000 / CLK_NS;

   // Mode change delays, ns (least times, rounded up)
   localparam int START_NS = 50000;
   localparam int WAKE_NS = 20000;
   localparam int SLEEP_NS = 20000;
   localparam int SHDN_NS = 10000;
   localparam int RCVR_NS = 40000;
   localparam int START_CYC = (START_NS + CLK_NS - 1) / CLK_NS;
   localparam int WAKE_CYC = (WAKE_NS + CLK_NS - 1) / CLK_NS;
   localparam int SLEEP_CYC = (SLEEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int SHDN_CYC = (SHDN_NS + CLK_NS - 1) / CLK_NS;
   localparam int RCVR_CYC = (RCVR_NS + CLK_NS - 1) / CLK_NS;

   // Counter types
   typedef logic [11:0] dly_cnt_t;
   typedef logic [8:0] ocf_cnt_t;
   typedef logic [17:0] rty_cnt_t;

   // Modes, Gray coded along shutdown-sleep-operating-fault
   typedef enum logic [1:0] {
      MODE_SHDN = 2'h0,
      MODE_SLEEP = 2'h1,
      MODE_OPER = 2'h3,
      MODE_FAULT = 2'h2
   } mode_t;

   // Delay conditions being timed
   localparam logic [2:0] COND_NONE = 3'h0;
   localparam logic [2:0] COND_START = 3'h1;
   localparam logic [2:0] COND_WAKE = 3'h2;
   localparam logic [2:0] COND_SLEEP = 3'h3;
   localparam logic [2:0] COND_SHDN = 3'h4;
   localparam logic [2:0] COND_RCVR_SLP = 3'h5;
   localparam logic [2:0] COND_RCVR_OPR = 3'h6;

   // Function bit positions in a disable vector (active low)
   localparam int FN_GATE = 0;
   localparam int FN_CHAIN = 1;
   localparam int FN_AUX = 2;

   // Per-source disables: [3] thermal warn, [2] thermal shutdown,
   // [1] gate supply low, [0] shunt overcurrent
   localparam logic [3:0][2:0] FAULT_DIS_N = {3'h7, 3'h4, 3'h4, 3'h6};
   // Per-source permission to return to operating
   localparam logic [3:0] FAULT_RECOVER = 4'hB;

   // Pins sampled through the synchroniser
   typedef struct packed {
      logic vcc_ok;
      logic vcc_low;
      logic en;
      logic shunt_oc;
      logic [2:0] fsrc;
      logic [2:0] hs;
      logic [2:0] ls;
   } pins_t;

   // Registered outputs
   typedef struct packed {
      logic prim;
      logic aux;
      logic bb;
      logic cp;
      logic drv;
      logic [2:0] hs;
      logic [2:0] ls;
      logic fault_n;
      logic [3:0] status;
      logic [1:0] mode;
   } outs_t;

   // Output values after reset
   localparam outs_t OUT_RST = '{prim: 1'h1, fault_n: 1'h1, default: '0};

endpackage

// [sim/mcu_model.sv]
// Behavioural motor controller facing the mode sequencer.
// Assumes the bench sets requests just after a rising edge.
module mcu_model (
   input wire logic clk_i, // System clock
   input wire logic rst_i, // Async reset, high
   input wire logic en_req_i, // Bench wants enable
   input wire logic [2:0] hs_req_i, // Bench high side pattern
   input wire logic [2:0] ls_req_i, // Bench low side pattern
   input wire logic fault_n_i, // Fault pin, low active
   output logic enable_o, // Enable pin
   output logic [2:0] hs_o, // High side commands
   output logic [2:0] ls_o, // Low side commands
   output logic fault_seen_o // Sticky: fault pin seen low
);
   // Pins launched on the edge, held until the bench changes them
   always @(posedge clk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         enable_o <= 1'h0;
         hs_o <= 3'h0;
         ls_o <= 3'h0;
         fault_seen_o <= 1'h0;
      end
      else
      begin
         enable_o <= en_req_i; // Raised and held while wanted
         hs_o <= hs_req_i;
         ls_o <= ls_req_i;
         // Sticky so a short report is never lost
         if (!fault_n_i)
            fault_seen_o <= 1'h1;
      end
   end
endmodule

// [sim/test_gate_driver_mode_sequencer.sv]
// Self-checking bench for the gate driver mode sequencer.
// Assumes the controller model in mcu_model.sv; 50 MHz clock.
module test_gate_driver_mode_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RTY = 400; // Short long-retry keeps the run brief
   localparam int LIMIT = 60000; // Cycle ceiling for a hang
   logic clk_sys_i = 0, rst_i = 1, rise = 0, fall = 1, trip = 0;
   logic ser = 0, rsel = 0, en_req = 0;
   logic [1:0] fsel = 0;
   logic [2:0] fsrc = 0, hs_req = 0, ls_req = 0, hs_c, ls_c, hs_g, ls_g;
   logic [3:0] clr = 0, status;
   logic en, prim, aux, bb, cp, drv, fault_n, seen_f;
   logic [1:0] mode;
   int error_cnt = 0, tests_run = 0, cyc = 0;

   // Clock, 20 ns period
   initial
   begin
      forever #10 clk_sys_i = ~clk_sys_i;
   end

   gate_driver_mode_sequencer #(.RETRY_LONG_CYC(RTY)) dut (
      .clk_sys_i(clk_sys_i), .rst_i(rst_i), .vcc_above_rise_i(rise),
      .vcc_below_fall_i(fall), .enable_i(en), .shunt_trip_i(trip),
      .fault_src_i(fsrc), .high_side_cmd_i(hs_c), .low_side_cmd_i(ls_c),
      .serial_cfg_i(ser), .overcurrent_filter_sel_i(fsel),
      .shunt_trip_retry_sel_i(rsel), .status_clr_i(clr),
      .primary_regulator_en_o(prim), .aux_regulator_en_o(aux),
      .buck_boost_en_o(bb), .charge_pump_en_o(cp),
      .drive_regulator_en_o(drv), .high_side_gate_o(hs_g),
      .low_side_gate_o(ls_g), .fault_out_n_o(fault_n),
      .fault_status_o(status), .mode_o(mode));

   mcu_model mcu (.clk_i(clk_sys_i), .rst_i(rst_i), .en_req_i(en_req),
      .hs_req_i(hs_req), .ls_req_i(ls_req), .fault_n_i(fault_n),
      .enable_o(en), .hs_o(hs_c), .ls_o(ls_c), .fault_seen_o(seen_f));

   // Verdict and end of run, reached from every path
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic check(string name, logic [4:0] got, logic [4:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %h seen %h", name, exp, got);
         error_cnt++;
      end
   endtask

   // Let n edges pass, then step off the edge
   task automatic step(int n);
      repeat (n) @(posedge clk_sys_i);
      #1;
   endtask

   // Bounded wait for a mode code, then judge it
   task automatic wait_mode(logic [1:0] m, int lim);
      int n;
      n = 0;
      while (mode !== m && n < lim)
      begin
         step(1);
         n++;
      end
      check("mode", 5'(mode), 5'(m));
   endtask

   // Supply up and enable: shutdown, sleep, then operating
   task automatic power_up();
      en_req = 0;
      fall = 0;
      rise = 1;
      wait_mode(mode_seq_pkg::MODE_SLEEP,
         mode_seq_pkg::START_CYC + 10);
      en_req = 1;
      wait_mode(mode_seq_pkg::MODE_OPER,
         mode_seq_pkg::WAKE_CYC + 10);
   endtask

   // Hang guard
   always @(posedge clk_sys_i)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         error_cnt++;
         test_done();
      end
   end

   initial
   begin
      int len [4];
      len[0] = mode_seq_pkg::OCF_1P4_CYC;
      len[1] = mode_seq_pkg::OCF_2P2_CYC;
      len[2] = mode_seq_pkg::OCF_3P2_CYC;
      len[3] = mode_seq_pkg::OCF_5P4_CYC;
      step(20);
      rst_i = 0;
      step(5);
      check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_SHDN));
      check("regs", {prim, aux, bb, cp, drv}, 5'h10);
      $display("test reset done");
      // Supply up: startup delay, then sleep
      fall = 0;
      rise = 1;
      step(mode_seq_pkg::START_CYC);
      check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_SHDN));
      wait_mode(mode_seq_pkg::MODE_SLEEP, 20);
      check("regs", {prim, aux, bb, cp, drv}, 5'h18);
      hs_req = 3'h7;
      step(6);
      check("gates", 5'(hs_g), 5'h00);
      $display("test startup done");
      // Enable with a glitch: wake delay must restart
      en_req = 1;
      step(mode_seq_pkg::WAKE_CYC - 200);
      en_req = 0;
      step(3);
      en_req = 1;
      step(mode_seq_pkg::WAKE_CYC - 100);
      check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_SLEEP));
      wait_mode(mode_seq_pkg::MODE_OPER, 120);
      check("regs", {prim, aux, bb, cp, drv}, 5'h0F);
      hs_req = 3'h5;
      ls_req = 3'h3;
      step(5);
      check("gates", {hs_g, ls_g[1:0]}, 5'h12);
      $display("test wake done");
      // Strap filter 3.2us; retry select ignored under strap
      rsel = 1;
      trip = 1;
      step(150);
      trip = 0;
      step(10);
      check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_OPER));
      trip = 1;
      wait_mode(mode_seq_pkg::MODE_FAULT, 175);
      check("flt", {fault_n, hs_g, drv}, 5'h01);
      check("stat", 5'(status[0]), 5'h01);
      trip = 0;
      wait_mode(mode_seq_pkg::MODE_OPER, RTY + 2020);
      check("seen", 5'(seen_f), 5'h01);
      $display("test strap trip done");
      // Serial filter selects, short retry
      ser = 1;
      for (int i = 0; i < 4; i++)
      begin
         fsel = 2'(i);
         trip = 1;
         step(len[i] - 4);
         trip = 0;
         step(10);
         check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_OPER));
         trip = 1;
         wait_mode(mode_seq_pkg::MODE_FAULT, len[i] + 10);
         trip = 0;
         step(2600);
         check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_FAULT));
         wait_mode(mode_seq_pkg::MODE_OPER, 3000);
      end
      $display("test serial filter done");
      // Enable low while operating: sleep entry delay, then wake again
      en_req = 0;
      step(mode_seq_pkg::SLEEP_CYC);
      check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_OPER));
      wait_mode(mode_seq_pkg::MODE_SLEEP, 10);
      check("regs", {prim, aux, bb, cp, drv}, 5'h18);
      en_req = 1;
      wait_mode(mode_seq_pkg::MODE_OPER, mode_seq_pkg::WAKE_CYC + 10);
      $display("test sleep entry done");
      // Thermal shutdown plus warning: no recovery, enable low exits
      fsrc = 3'h2;
      wait_mode(mode_seq_pkg::MODE_FAULT, 10);
      check("regs", {prim, bb, hs_g}, 5'h10);
      fsrc = 3'h6;
      step(10);
      check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_FAULT));
      fsrc = 0;
      step(mode_seq_pkg::RCVR_CYC + 100);
      check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_FAULT));
      en_req = 0;
      wait_mode(mode_seq_pkg::MODE_SLEEP,
         mode_seq_pkg::RCVR_CYC + 20);
      check("stat", 5'(status), 5'h0D);
      clr = 4'hF;
      step(1);
      clr = 0;
      step(2);
      check("stat", 5'(status), 5'h00);
      $display("test thermal done");
      // Supply drop from sleep waits out the shutdown delay
      fall = 1;
      rise = 0;
      step(mode_seq_pkg::SHDN_CYC);
      check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_SLEEP));
      wait_mode(mode_seq_pkg::MODE_SHDN, 10);
      check("regs", {prim, aux, bb, cp, drv}, 5'h10);
      // Gate supply fault, then supply drop from fault mode
      power_up();
      fsrc = 3'h1;
      wait_mode(mode_seq_pkg::MODE_FAULT, 10);
      check("regs", {prim, bb, hs_g}, 5'h10);
      fall = 1;
      rise = 0;
      step(mode_seq_pkg::SHDN_CYC);
      check("mode", 5'(mode), 5'(mode_seq_pkg::MODE_FAULT));
      wait_mode(mode_seq_pkg::MODE_SHDN, 10);
      // Supply drop while operating is immediate
      fsrc = 0;
      power_up();
      fall = 1;
      rise = 0;
      wait_mode(mode_seq_pkg::MODE_SHDN, 5);
      check("regs", {prim, aux, bb, cp, drv}, 5'h10);
      $display("test supply drop done");
      test_done();
   end
endmodule
